// *** design/dtmf_pkg.sv ***
// Package for the tone transceiver host port: register map, fields, reset values, timing.
// Assumes a 200 MHz ref_clk and an APB master with 32-bit data.
package dtmf_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_DATA = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [3:0] CTRL_FIRST_RESET = 4'h0;
  localparam logic [3:0] CTRL_SECOND_RESET = 4'h0;
  localparam logic [3:0] TX_RESET = 4'h0;
  localparam logic [3:0] RX_RESET = 4'h0;
  localparam int unsigned FIRST_TONE_BIT = 0;
  localparam int unsigned FIRST_MODE_BIT = 1;
  localparam int unsigned FIRST_IRQ_BIT = 2;
  localparam int unsigned FIRST_BANK_BIT = 3;
  localparam int unsigned SECOND_BURST_BIT = 0;
  localparam int unsigned STAT_TXRDY_BIT = 1;
  localparam int unsigned STAT_VALID_BIT = 2;
  localparam int unsigned STAT_DSTEER_BIT = 3;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned BURST_MS = 51;
  localparam int unsigned BURST_CYCLES = CLK_HZ / 1000 * BURST_MS;

  typedef struct packed {
    logic early;
    logic steer;
    logic [3:0] code;
  } tone_in_s;

  typedef struct packed {
    logic [3:0] first;
    logic [3:0] second;
  } ctrl_s;
endpackage

// *** design/dtmf_transceiver_host_port.sv ***
// Host-side register bank of a tone transceiver: data, control and status registers on APB.
// Assumes a tone detector delivers early-detect, steering level and a decoded code in sync.
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps

// Summary of operation
// RULE_01 - Five registers: tx, rx, two control, status
// RULE_02 - Receive code is read only
// RULE_03 - Transmit code is write only, selects tones
// RULE_04 - Both control registers share one address
// RULE_05 - Bank select routes only next control write
// RULE_06 - Bank select is control bit three
// RULE_07 - Host initialises control and status first
// RULE_08 - Interrupt on valid tone or burst ready
// RULE_09 - Control bit two enables interrupt, tone mode
// RULE_10 - Interrupt output is open drain
// RULE_11 - Short tones leave receive code unchanged
// RULE_12 - Valid tone latches decoded code
// RULE_13 - Code kept until next valid tone
// RULE_14 - Short dropout keeps code unchanged
// RULE_15 - Validity only after full guard time
// RULE_16 - Status bit three low during valid tone
// RULE_17 - Status bit two set, cleared by read
// RULE_18 - Receive interrupt cleared by status read
// RULE_19 - Early steering follows raw tone detection
// RULE_20 - Oscillator reference supplied from outside
// RULE_21 - Steering input sampled on own clock
module dtmf_transceiver_host_port #(
  parameter int unsigned BURST_LEN = dtmf_pkg::BURST_CYCLES
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dtmf_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire dtmf_pkg::tone_in_s toneIn,
  output logic earlySteeringOutput,
  output logic interruptProgressOutput,
  output logic interruptProgressOe,
  output logic [3:0] txCode,
  output logic toneEnable,
  output logic progressModeBit,
  output logic burstMode,
  output logic txActive
);

  dtmf_pkg::ctrl_s ctrl;
  logic [3:0] receiveCodeBits;
  logic bankPending;
  logic steerSeen;
  logic dataValid;
  logic txReady;
  logic [31:0] burstCount;
  logic burstPhase;
  logic txLoaded;

  logic access;
  logic wrData;
  logic wrCtrl;
  logic rdData;
  logic rdStat;
  logic badAddr;
  logic newCode;
  logic irqCause;
  logic burstStart;
  logic burstEnd;
  logic [31:0] next_prdata;

  assign access = psel && penable && pready;
  assign wrData = access && pwrite && paddr == dtmf_pkg::OFF_DATA;
  assign wrCtrl = access && pwrite && paddr == dtmf_pkg::OFF_CTRL;
  assign rdData = access && !pwrite && paddr == dtmf_pkg::OFF_DATA;
  assign rdStat = access && !pwrite && paddr == dtmf_pkg::OFF_CTRL;
  assign badAddr = paddr != dtmf_pkg::OFF_DATA && paddr != dtmf_pkg::OFF_CTRL;
  // Guard-qualified steering rising edge; tone decode inhibited in progress mode
  assign newCode = toneIn.steer && !steerSeen && !ctrl.first[dtmf_pkg::FIRST_MODE_BIT]; // [RULE_12] [RULE_15]

  // APB ready: no wait state, setup then access answered
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !pready;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel && !pready && badAddr;
    end
  end

  // Read mux: rx data at data address, status at control address [RULE_01]
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (paddr == dtmf_pkg::OFF_DATA) begin
      next_prdata[3:0] = receiveCodeBits; // [RULE_02]
    end else if (paddr == dtmf_pkg::OFF_CTRL) begin
      next_prdata[dtmf_pkg::STAT_DSTEER_BIT] = !steerSeen; // [RULE_16]
      next_prdata[dtmf_pkg::STAT_VALID_BIT] = dataValid; // [RULE_17]
      next_prdata[dtmf_pkg::STAT_TXRDY_BIT] = txReady;
      next_prdata[0] = dataValid || txReady;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !pready && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  // Transmit code, write only
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      txCode <= dtmf_pkg::TX_RESET;
    end else if (wrData) begin
      txCode <= pwdata[3:0]; // [RULE_03]
    end
  end

  // First control register: written unless bank select was armed
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ctrl.first <= dtmf_pkg::CTRL_FIRST_RESET;
    end else if (wrCtrl && !bankPending) begin
      ctrl.first <= pwdata[3:0]; // [RULE_04]
    end
  end

  // Second control register: takes exactly one write after bank select
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ctrl.second <= dtmf_pkg::CTRL_SECOND_RESET;
    end else if (wrCtrl && bankPending) begin
      ctrl.second <= pwdata[3:0]; // [RULE_05]
    end
  end

  // Bank select armed by bit three, spent by the next control write
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      bankPending <= 1'b0;
    end else if (wrCtrl) begin
      if (bankPending) begin
        bankPending <= 1'b0; // [RULE_05]
      end else begin
        bankPending <= pwdata[dtmf_pkg::FIRST_BANK_BIT]; // [RULE_06]
      end
    end
  end

  // Steering level sampled each clock; code latched only on qualified edge
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      steerSeen <= 1'b0;
    end else begin
      steerSeen <= toneIn.steer; // [RULE_21] [RULE_14]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      receiveCodeBits <= dtmf_pkg::RX_RESET;
    end else if (newCode) begin
      receiveCodeBits <= toneIn.code; // [RULE_12] [RULE_13] [RULE_11]
    end
  end

  // Valid flag: set wins over status-read clear
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      dataValid <= 1'b0;
    end else if (newCode) begin
      dataValid <= 1'b1; // [RULE_17]
    end else if (rdStat) begin
      dataValid <= 1'b0; // [RULE_18]
    end
  end

  // Last count of one burst or pause; progress mode doubles its length
  function automatic logic [31:0] burstLimit(input logic longMode);
    burstLimit = longMode ? 32'(2 * BURST_LEN - 1) : 32'(BURST_LEN - 1);
  endfunction

  // Burst timer: tone for a burst, then pause, then ready for more data
  assign burstStart = wrData && ctrl.second[dtmf_pkg::SECOND_BURST_BIT];
  assign burstEnd = txLoaded &&
    burstCount >= burstLimit(ctrl.first[dtmf_pkg::FIRST_MODE_BIT]);

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      burstCount <= 32'h0000_0000;
    end else if (burstStart || burstEnd) begin
      burstCount <= 32'h0000_0000;
    end else if (txLoaded) begin
      burstCount <= burstCount + 32'h0000_0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      burstPhase <= 1'b0;
    end else if (burstStart) begin
      burstPhase <= 1'b0;
    end else if (burstEnd) begin
      burstPhase <= !burstPhase;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      txLoaded <= 1'b0;
    end else if (burstStart) begin
      txLoaded <= 1'b1;
    end else if (burstEnd && burstPhase) begin
      txLoaded <= 1'b0;
    end
  end

  // Ready flag: set after the pause wins over status-read clear
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      txReady <= 1'b0;
    end else if (burstStart) begin
      txReady <= 1'b0;
    end else if (burstEnd && burstPhase) begin
      txReady <= 1'b1;
    end else if (rdStat) begin
      txReady <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      toneEnable <= 1'b0;
    end else begin
      toneEnable <= ctrl.first[dtmf_pkg::FIRST_TONE_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      progressModeBit <= 1'b0;
    end else begin
      progressModeBit <= ctrl.first[dtmf_pkg::FIRST_MODE_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      burstMode <= 1'b0;
    end else begin
      burstMode <= ctrl.second[dtmf_pkg::SECOND_BURST_BIT];
    end
  end

  // Tone on: always when enabled, or only in the burst half in burst mode
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      txActive <= 1'b0;
    end else begin
      txActive <= ctrl.first[dtmf_pkg::FIRST_TONE_BIT] &&
        (!ctrl.second[dtmf_pkg::SECOND_BURST_BIT] || (txLoaded && !burstPhase)); // [RULE_03]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      earlySteeringOutput <= 1'b0;
    end else begin
      earlySteeringOutput <= toneIn.early; // [RULE_19]
    end
  end

  // Open drain: only pulls low; enable high while driving
  assign irqCause = ctrl.first[dtmf_pkg::FIRST_IRQ_BIT] &&
    !ctrl.first[dtmf_pkg::FIRST_MODE_BIT] &&
    (dataValid || (txReady && ctrl.second[dtmf_pkg::SECOND_BURST_BIT])); // [RULE_08] [RULE_09]

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      interruptProgressOutput <= 1'b0;
    end else begin
      interruptProgressOutput <= 1'b0; // [RULE_10]
    end
  end

  // Pin pulled low while an enabled interrupt cause stands
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      interruptProgressOe <= 1'b0;
    end else begin
      interruptProgressOe <= irqCause; // [RULE_18]
    end
  end

endmodule

// *** bench/tone_source.sv ***
// Tone detector stand-in: early detect, guarded steering, code.
// Assumes the host port samples these levels on ref_clk.
`timescale 1ns/1ps
module tone_source #(
  parameter int GUARD = 8
) (
  input wire logic ref_clk,
  output dtmf_pkg::tone_in_s toneIn
);
  initial toneIn = 6'h0F;
  task on(input logic [3:0] c, input logic ok);
    @(posedge ref_clk);
    toneIn.code <= c;
    toneIn.early <= 1'b1;
    repeat (GUARD) @(posedge ref_clk);
    if (ok) toneIn.steer <= 1'b1;
    else begin
      toneIn.early <= 1'b0;
      toneIn.code <= ~c;
    end
  endtask
  task off;
    @(posedge ref_clk);
    toneIn.early <= 1'b0;
    toneIn.code <= ~toneIn.code;
    repeat (GUARD) @(posedge ref_clk);
    toneIn.steer <= 1'b0;
  endtask
  task drop;
    @(posedge ref_clk);
    toneIn.early <= 1'b0;
    repeat (2) @(posedge ref_clk);
    toneIn.early <= 1'b1;
  endtask
endmodule

// *** bench/dtmf_host_port_assertions.sv ***
// Checker for the tone transceiver host port.
// Assumes wait-free APB answers; bound to the top module.
`timescale 1ns/1ps
module dtmf_host_port_assertions (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire dtmf_pkg::tone_in_s toneIn,
  input wire logic earlySteeringOutput,
  input wire logic interruptProgressOutput,
  input wire logic interruptProgressOe,
  input wire logic [3:0] txCode,
  input wire logic progressModeBit,
  input wire logic burstMode
);
  logic [3:0] lastWr;
  logic lastEarly;
  always_ff @(posedge ref_clk) lastWr <= pwdata[3:0];
  always_ff @(posedge ref_clk) lastEarly <= toneIn.early;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_done; psel && penable && pready; endsequence
  sequence s_rd; s_done ##0 (!pwrite && paddr == dtmf_pkg::OFF_CTRL); endsequence
  property p_answer; s_setup |=> s_done; endproperty
  property p_pulse; pready |=> !pready; endproperty
  property p_map;
    pready |-> pslverr == !(paddr == dtmf_pkg::OFF_DATA || paddr == dtmf_pkg::OFF_CTRL);
  endproperty
  property p_tx; s_done ##0 (pwrite && paddr == dtmf_pkg::OFF_DATA) |=> txCode == lastWr; endproperty
  property p_early; $past(resetn) |-> earlySteeringOutput == lastEarly; endproperty
  property p_open; interruptProgressOutput == 1'b0; endproperty
  property p_mode; progressModeBit && $past(progressModeBit) |-> !interruptProgressOe; endproperty
  property p_clear; (!toneIn.steer && !burstMode)[*3] ##0 s_rd |=> ##1 !interruptProgressOe; endproperty
  a_answer: assert property (p_answer) else $error("no answer after setup");
  a_pulse: assert property (p_pulse) else $error("ready too long");
  a_map: assert property (p_map) else $error("bad error flag");
  a_tx: assert property (p_tx) else $error("tx code not taken");
  a_early: assert property (p_early) else $error("early steer wrong");
  a_open: assert property (p_open) else $error("pin driven high");
  a_mode: assert property (p_mode) else $error("irq in progress mode");
  a_clear: assert property (p_clear) else $error("irq kept after read");
endmodule
bind dtmf_transceiver_host_port dtmf_host_port_assertions dtmf_host_port_assertions_inst (
  .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .toneIn(toneIn),
  .earlySteeringOutput(earlySteeringOutput), .interruptProgressOutput(interruptProgressOutput),
  .interruptProgressOe(interruptProgressOe), .txCode(txCode),
  .progressModeBit(progressModeBit), .burstMode(burstMode));

// *** bench/dtmf_transceiver_host_port_tb.sv ***
// Testbench for the tone transceiver host port.
// Assumes wait-free APB answers and a burst length of 20 cycles.
`timescale 1ns/1ps
module dtmf_transceiver_host_port_tb;
  localparam logic [7:0] D = dtmf_pkg::OFF_DATA;
  localparam logic [7:0] C = dtmf_pkg::OFF_CTRL;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [3:0] txCode, c1;
  logic pready, pslverr, early, irq, oe, toneEn, cpMode, burst, txAct;
  dtmf_pkg::tone_in_s toneIn;
  logic [33:0] expQ[$];
  logic [33:0] e;
  int err_count = 0;
  int cmp_count = 0;
  always #2.5 ref_clk = ~ref_clk;
  dtmf_transceiver_host_port #(.BURST_LEN(20)) dtmf_transceiver_host_port_inst (
    .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .toneIn(toneIn), .earlySteeringOutput(early), .interruptProgressOutput(irq),
    .interruptProgressOe(oe), .txCode(txCode), .toneEnable(toneEn),
    .progressModeBit(cpMode), .burstMode(burst), .txActive(txAct));
  tone_source tone_source_inst (.ref_clk(ref_clk), .toneIn(toneIn));
  task check(input string n, input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, x, s);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [33:0] x);
    expQ.push_back(x);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 34'h0);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] d);
    apb(1'b0, a, 32'h0, {2'b10, d});
  endtask
  task wait_oe(input int n);
    repeat (n) if (oe !== 1'b1) @(posedge ref_clk);
    check("oe", 32'(oe), 32'h1);
  endtask
  task end_sim;
    $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    if (psel && penable && pready === 1'b1) begin
      e = expQ.pop_front();
      check("pslverr", 32'(pslverr), 32'(e[32]));
      if (e[33]) check("prdata", prdata, e[31:0]);
    end
  end
  initial begin
    #100000;
    err_count++;
    end_sim;
  end
  initial begin
    void'($urandom(69883));
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    rd(D, 32'h0);
    rd(C, 32'h8);
    wr(C, 32'h5);
    c1 = 4'($urandom);
    wr(D, {28'h0, c1});
    check("txCode", 32'(txCode), 32'(c1));
    rd(D, 32'h0);
    tone_source_inst.on(~c1, 1'b0);
    rd(D, 32'h0);
    c1 = 4'($urandom);
    tone_source_inst.on(c1, 1'b1);
    wait_oe(30);
    rd(C, 32'h5);
    @(posedge ref_clk);
    check("oe", 32'(oe), 32'h0);
    tone_source_inst.drop();
    rd(C, 32'h0);
    tone_source_inst.off();
    rd(D, {28'h0, c1});
    rd(C, 32'h8);
    wr(C, 32'hD);
    wr(C, 32'h1);
    wr(C, 32'h4);
    @(posedge ref_clk);
    check("burst", 32'(burst), 32'h1);
    check("toneEn", 32'(toneEn), 32'h0);
    wr(C, 32'h5);
    wr(D, {28'h0, c1});
    @(posedge ref_clk);
    check("txAct", 32'(txAct), 32'h1);
    wait_oe(200);
    check("txAct", 32'(txAct), 32'h0);
    rd(C, 32'hB);
    rd(C, 32'h8);
    wr(C, 32'h7);
    repeat (2) @(posedge ref_clk);
    check("cpMode", 32'(cpMode), 32'h1);
    check("oe", 32'(oe), 32'h0);
    apb(1'b0, 8'h08, 32'h0, {2'b01, 32'h0});
    apb(1'b1, 8'h08, 32'hF, {2'b01, 32'h0});
    end_sim;
  end
endmodule
